//--- pkg/dfs_pkg.sv
`default_nettype none
package dfs_pkg;
  // Clock and blink timing.
  localparam int unsigned ClkHz       = 100_000_000;
  localparam int unsigned TickUs      = 1000;
  localparam int unsigned TickCycles  = ClkHz / 1_000_000 * TickUs;
  localparam int unsigned SlowHalfMs  = 500;
  localparam int unsigned FastHalfMs  = 100;
  localparam int unsigned FlashOnMs   = 200;
  localparam int unsigned FlashGapMs  = 300;
  localparam int unsigned GroupGapMs  = 1500;
  localparam int unsigned MsW         = 12;

  // Register addresses and reset values.
  localparam logic [7:0] AddrStatus  = 8'h00;
  localparam logic [7:0] AddrIrqStat = 8'h04;
  localparam logic [7:0] AddrIrqMask = 8'h08;
  localparam logic [7:0] AddrControl = 8'h0C;
  localparam logic [7:0] AddrCommand = 8'h10;
  localparam logic [31:0] ControlReset = 32'h0000_0000;
  localparam logic [31:0] MaskReset    = 32'h0000_0000;

  // Bit positions.
  localparam int unsigned CtlPolBit  = 0;
  localparam int unsigned CtlRstIn   = 1;
  localparam int unsigned CmdClrBit  = 0;
  localparam int unsigned CmdProbe   = 1;
  localparam int unsigned IrqFault   = 0;
  localparam int unsigned IrqShut    = 1;
  localparam int unsigned IrqUnprob  = 2;

  // Fault codes equal the red flash count.
  localparam logic [2:0] CodeNone = 3'h0;
  localparam int unsigned NumFaults = 7;

  typedef enum logic [1:0] {LedOff, LedGreen, LedRed} dfs_led_t;

  typedef struct packed {
    logic stall;
    logic underVolt;
    logic overVolt;
    logic overCurrent;
    logic overTemp;
    logic checksumBad;
  } dfs_fault_in_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dfs_bus_t;
endpackage
`default_nettype wire

//--- logic/dfs_flash_seq.sv
`timescale 1ns/1ps
`default_nettype none
module dfs_flash_seq (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Millisecond enable and the flash count to show, zero for idle.
  input  wire logic        msTick,
  input  wire logic [2:0]  count,
  // Red lamp on.
  output logic             redOn
);
  import dfs_pkg::*;

  typedef enum {SeqIdle, SeqOn, SeqGap, SeqPause} dfs_seq_t;
  dfs_seq_t          state;
  logic [MsW-1:0]    msCnt;
  logic [2:0]        done;

  // group pause: a long dark pause then repeat, so the count reads cleanly.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || count == CodeNone) begin
      state <= SeqIdle;
      msCnt <= '0;
      done  <= '0;
    end else if (state == SeqIdle) begin
      state <= SeqOn;
      msCnt <= '0;
      done  <= '0;
    end else if (msTick) begin
      msCnt <= msCnt + 1'b1;
      unique case (state)
        SeqOn: if (msCnt == MsW'(FlashOnMs - 1)) begin
          msCnt <= '0;
          done  <= done + 1'b1;
          state <= (done + 1'b1 == count) ? SeqPause : SeqGap;
        end
        SeqGap: if (msCnt == MsW'(FlashGapMs - 1)) begin
          msCnt <= '0;
          state <= SeqOn;
        end
        SeqPause: if (msCnt == MsW'(GroupGapMs - 1)) begin
          msCnt <= '0;
          done  <= '0;
          state <= SeqOn;
        end
        default: state <= SeqIdle;
      endcase
    end
  end

  assign redOn = (state == SeqOn);

  // pause stays dark: the lamp stays off until the pause count runs out.
  a_pause_dark: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == SeqPause && !msTick |=> !redOn) else $error("Lamp lit during group pause.");
endmodule // dfs_flash_seq
`default_nettype wire

//--- logic/dfs_fault_status.sv
`timescale 1ns/1ps
`default_nettype none
module dfs_fault_status (
  // Clock and reset.
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // Register port.
  input  wire dfs_pkg::dfs_bus_t     bus,
  output logic [31:0]                rdData,
  // Drive conditions.
  input  wire dfs_pkg::dfs_fault_in_t faultIn,
  input  wire logic                  motor_safety_loop,
  input  wire logic                  disable_request_input,
  input  wire logic                  resetInput,
  input  wire logic                  regenDump,
  // Drive outputs.
  output logic                       ampEnable,
  output logic                       faultOut,
  output logic                       ledGreen,
  output logic                       ledRed,
  output logic                       irq
);
  import dfs_pkg::*;

  logic [31:0]          control;
  logic [2:0]           irqStat;
  logic [2:0]           irqMask;
  logic [NumFaults-1:0] latched;
  logic [2:0]           firstCode;
  logic                 unprobed;
  logic [$clog2(TickCycles)-1:0] tickCnt;
  logic                 msTick;
  logic [MsW-1:0]       blinkCnt;
  logic                 slowPh;
  logic                 fastPh;
  logic                 redFlash;
  logic                 shutdown;
  logic                 clearReq;
  logic                 resetInPrev;
  logic [NumFaults-1:0] next_raw;
  logic [2:0]           rdIrq;

  wire writeHit = bus.wr;

  // Turns the raw fault inputs into a vector indexed by flash count minus one.
  function automatic logic [NumFaults-1:0] faultVec(input dfs_fault_in_t f, input logic loopOk);
    faultVec = {f.checksumBad, f.overTemp, !loopOk, f.overCurrent,
                f.overVolt, f.underVolt, f.stall};
  endfunction

  // Lowest set bit becomes a flash count.
  function automatic logic [2:0] codeOf(input logic [NumFaults-1:0] v);
    codeOf = CodeNone;
    for (int i = NumFaults - 1; i >= 0; i--) begin
      if (v[i]) codeOf = 3'(i + 1);
    end
  endfunction

  assign next_raw = faultVec(faultIn, motor_safety_loop);

  // shutdown polarity: the control bit selects the active level.
  assign shutdown = disable_request_input ^ control[CtlPolBit];

  // clear sources: command write or a rising edge on the reset input.
  assign clearReq = (writeHit && bus.addr == AddrCommand && bus.wdata[CmdClrBit])
                  || (control[CtlRstIn] && resetInput && !resetInPrev);

  // Edge detect on the reset input.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      resetInPrev <= 1'b0;
    end else begin
      resetInPrev <= resetInput;
    end
  end

  // latch faults; a fault present during clear stays latched.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      latched <= '0;
    end else if (clearReq) begin
      latched <= next_raw;
    end else begin
      latched <= latched | next_raw;
    end
  end

  // first fault: the displayed code is frozen until a clear request.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      firstCode <= CodeNone;
    end else if (clearReq) begin
      firstCode <= codeOf(next_raw);
    end else if (firstCode == CodeNone) begin
      firstCode <= codeOf(next_raw);
    end
  end

  // probe state: power-up is unprobed until software probes the motor.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      unprobed <= 1'b1;
    end else if (writeHit && bus.addr == AddrCommand && bus.wdata[CmdProbe]) begin
      unprobed <= 1'b0;
    end
  end

  // Millisecond enable; blink phases derive from it rather than a second clock.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || msTick) begin
      tickCnt <= '0;
    end else begin
      tickCnt <= tickCnt + 1'b1;
    end
  end
  assign msTick = (tickCnt == ($clog2(TickCycles))'(TickCycles - 1));

  // blink phases: slow and fast toggle from one millisecond counter.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      blinkCnt <= '0;
      slowPh   <= 1'b0;
      fastPh   <= 1'b0;
    end else if (msTick) begin
      blinkCnt <= (blinkCnt == MsW'(SlowHalfMs - 1)) ? '0 : blinkCnt + 1'b1;
      if (blinkCnt == MsW'(SlowHalfMs - 1)) begin
        slowPh <= !slowPh;
      end
      if (blinkCnt % MsW'(FastHalfMs) == MsW'(FastHalfMs - 1)) begin
        fastPh <= !fastPh;
      end
    end
  end

  // flash groups: the sequencer emits the count of the first fault.
  dfs_flash_seq uFlash (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .msTick  (msTick),
    .count   (firstCode),
    .redOn   (redFlash)
  );

  // amplifier: off on shutdown or any latched fault.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ampEnable <= 1'b0;
    end else begin
      ampEnable <= !shutdown && next_raw == '0 && latched == '0 && !unprobed;
    end
  end

  // LED priority: faults, unprobed, shutdown, regen, then normal.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ledGreen <= 1'b0;
      ledRed   <= 1'b1;
    end else if (firstCode != CodeNone) begin
      ledGreen <= 1'b0;
      ledRed   <= redFlash;
    end else if (unprobed) begin
      ledGreen <= 1'b0;
      ledRed   <= 1'b1;
    end else if (shutdown) begin
      ledGreen <= slowPh;
      ledRed   <= 1'b0;
    end else if (regenDump) begin
      ledGreen <= fastPh;
      ledRed   <= 1'b0;
    end else begin
      ledGreen <= 1'b1;
      ledRed   <= 1'b0;
    end
  end

  // fault output: high while any fault or the unprobed state stands.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      faultOut <= 1'b1;
    end else begin
      faultOut <= (latched | next_raw) != '0 || unprobed;
    end
  end

  // Sticky events; a new event wins over a write-one clear in the same cycle.
  assign rdIrq = {unprobed, shutdown, (latched != '0)};
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irqStat <= '0;
    end else begin
      irqStat <= (irqStat & ~((writeHit && bus.addr == AddrIrqStat) ? bus.wdata[2:0] : 3'h0))
               | rdIrq;
    end
  end

  // Software registers.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      control <= ControlReset;
      irqMask <= MaskReset[2:0];
    end else if (writeHit) begin
      if (bus.addr == AddrControl) control <= {30'h0000_0000, bus.wdata[1:0]};
      if (bus.addr == AddrIrqMask) irqMask <= bus.wdata[2:0];
    end
  end

  assign irq = (irqStat & irqMask) != 3'h0;

  // Read data one cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdData <= '0;
    end else if (bus.rd) begin
      unique case (bus.addr)
        AddrStatus:  rdData <= {16'h0000, 1'b0, firstCode, 1'b0, unprobed, shutdown,
                                ampEnable, 1'b0, latched};
        AddrIrqStat: rdData <= {29'h0000_0000, irqStat};
        AddrIrqMask: rdData <= {29'h0000_0000, irqMask};
        AddrControl: rdData <= control;
        default:     rdData <= '0;
      endcase
    end else begin
      rdData <= '0;
    end
  end

  // shutdown disables: amplifier off one cycle after shutdown.
  a_shut_amp_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    shutdown |=> !ampEnable) else $error("Amplifier on during shutdown.");
  // enable when clear: clean conditions enable the amplifier.
  a_amp_enabled: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !shutdown && next_raw == '0 && latched == '0 && !unprobed |=> ampEnable)
    else $error("Amplifier off without cause.");
  // loop loss latches: safety loop loss cuts current and holds code five.
  a_loop_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !motor_safety_loop && !clearReq |=> !ampEnable && latched[4])
    else $error("Safety loop loss not latched.");
  // fault output: raised by a new fault next cycle.
  a_fault_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
    next_raw != '0 |=> faultOut) else $error("Fault output missing.");
  // stays while flashing: red implies fault output high.
  a_red_fault: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ledRed |-> faultOut) else $error("Red lamp without fault output.");
  // normal green: quiet drive shows steady green.
  a_green_normal: assert property (@(posedge clk_sys) disable iff (!rst_n)
    firstCode == CodeNone && !unprobed && !shutdown && !regenDump |=> ledGreen && !ledRed)
    else $error("Normal state not green.");
  // first held: the shown code never changes without a clear.
  a_first_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
    firstCode != CodeNone && !clearReq |=> $stable(firstCode))
    else $error("Displayed fault changed.");
  // unprobed red: steady red while unprobed and no fault shown.
  a_unprobed_red: assert property (@(posedge clk_sys) disable iff (!rst_n)
    unprobed && firstCode == CodeNone |=> ledRed && !ledGreen)
    else $error("Unprobed state not red.");
endmodule // dfs_fault_status
`default_nettype wire

//--- verification/dfs_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module dfs_ctrl_model (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Scenario requests.
  input  wire logic shutReq,
  input  wire logic shutHigh,
  input  wire logic resetReq,
  // Lines toward the drive.
  output logic      disable_request_input,
  output logic      resetInput
);
  logic [1:0] pulseLeft;

  // selectable request polarity
  // The controller encodes shutdown in whichever polarity the drive expects.
  always_ff @(posedge clk_sys) begin
    disable_request_input <= shutReq ~^ shutHigh;
  end

  // reset input pulse
  // Held three cycles so that a sampled edge detector cannot miss it.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pulseLeft <= 2'h0;
    end else if (resetReq) begin
      pulseLeft <= 2'h3;
    end else if (pulseLeft != 2'h0) begin
      pulseLeft <= pulseLeft - 2'h1;
    end
  end
  assign resetInput = (pulseLeft != 2'h0);
endmodule // dfs_ctrl_model
`default_nettype wire

//--- verification/dfs_fault_status_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dfs_fault_status_tb_top;
  import dfs_pkg::*;
  logic          clk_sys;
  logic          rst_n;
  dfs_bus_t      bus;
  logic [31:0]   rdData;
  dfs_fault_in_t fin;
  logic          loopOk, shutReq, shutHigh, resetReq, regenDump;
  logic          sdLine, rstLine;
  logic          ampEnable, faultOut, ledGreen, ledRed, irq;
  logic [31:0]   v, lf;
  int            miscompares, checkCount, a, b;

  dfs_fault_status dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .rdData(rdData),
    .faultIn(fin), .motor_safety_loop(loopOk), .disable_request_input(sdLine),
    .resetInput(rstLine), .regenDump(regenDump), .ampEnable(ampEnable),
    .faultOut(faultOut), .ledGreen(ledGreen), .ledRed(ledRed), .irq(irq));
  dfs_ctrl_model ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .shutReq(shutReq),
    .shutHigh(shutHigh), .resetReq(resetReq), .disable_request_input(sdLine),
    .resetInput(rstLine));

  // Free-running system clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Bus cycles hold every qualifier for exactly one edge.
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
    #1;
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{addr: ad, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    #1;
    d = rdData;
  endtask

  task automatic setFault(input int c, input logic on);
    case (c)
      1: fin.stall       <= on;
      2: fin.underVolt   <= on;
      3: fin.overVolt    <= on;
      4: fin.overCurrent <= on;
      5: loopOk          <= !on;
      6: fin.overTemp    <= on;
      default: fin.checksumBad <= on;
    endcase
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [31:0] outs();
    return {28'h000_0000, ampEnable, faultOut, ledGreen, ledRed};
  endfunction

  task automatic final_report();
    if (miscompares == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog so that a hung design still reaches the verdict.
  initial begin
    repeat (100000) @(posedge clk_sys);
    miscompares++;
    final_report();
  end

  // Main sequence.
  initial begin
    rst_n = 1'b0; bus = '0; fin = '0; loopOk = 1'b1; shutReq = 1'b0;
    shutHigh = 1'b1; resetReq = 1'b0; regenDump = 1'b0; lf = 32'h1e1c;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    step(1);
    check(outs(), 32'h5);
    rd(AddrStatus, v);
    check(32'(v[10]), 32'h1);
    rd(AddrControl, v);
    check(v, ControlReset);
    rd(8'h20, v);
    check(v, 32'h0);
    wr(AddrCommand, 32'h1 << CmdProbe);
    step(2);
    check(outs(), 32'ha);
    regenDump <= 1'b1;
    step(3);
    check(outs() & 32'hc, 32'h8);
    regenDump <= 1'b0;
    // Shutdown in both polarities.
    shutReq <= 1'b1;
    step(3);
    check(32'(ampEnable), 32'h0);
    wr(AddrControl, 32'h1);
    step(2);
    check(32'(ampEnable), 32'h1);
    shutHigh <= 1'b0;
    step(3);
    check(32'(ampEnable), 32'h0);
    shutReq <= 1'b0;
    step(3);
    check(32'(ampEnable), 32'h1);
    wr(AddrControl, 32'h0);
    shutHigh <= 1'b1;
    // Every fault code, with a clear refused while present.
    for (int c = 1; c <= NumFaults; c++) begin
      setFault(c, 1'b1);
      step(2);
      check(32'(faultOut), 32'h1);
      check(32'(ledGreen), 32'h0);
      if (c == 5) check(32'(ampEnable), 32'h0);
      rd(AddrStatus, v);
      check(32'(v[14:12]), 32'(c));
      wr(AddrCommand, 32'h1 << CmdClrBit);
      step(2);
      check(32'(faultOut), 32'h1);
      setFault(c, 1'b0);
      step(2);
      check(32'(faultOut), 32'h1);
      wr(AddrCommand, 32'h1 << CmdClrBit);
      step(2);
      check(32'(faultOut), 32'h0);
    end
    // Random pairs of faults: the first one stays on display.
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      a = 1 + int'(lf % 7);
      b = (a + int'((lf >> 4) % 6)) % 7 + 1;
      setFault(a, 1'b1);
      step(2);
      setFault(b, 1'b1);
      step(2);
      rd(AddrStatus, v);
      check(32'(v[14:12]), 32'(a));
      setFault(a, 1'b0);
      setFault(b, 1'b0);
      wr(AddrCommand, 32'h1 << CmdClrBit);
      step(2);
      check(32'(faultOut), 32'h0);
    end
    // Reset input clears only when enabled.
    for (int en = 1; en >= 0; en--) begin
      wr(AddrControl, en ? 32'h2 : 32'h0);
      setFault(1, 1'b1);
      step(2);
      setFault(1, 1'b0);
      resetReq <= 1'b1;
      step(1);
      resetReq <= 1'b0;
      step(6);
      check(32'(faultOut), 32'(!en));
    end
    // Interrupt: masked, unmasked, then cleared.
    check(32'(irq), 32'h0);
    wr(AddrIrqMask, 32'h1 << IrqFault);
    step(1);
    check(32'(irq), 32'h1);
    wr(AddrCommand, 32'h1 << CmdClrBit);
    wr(AddrIrqStat, 32'h7);
    step(1);
    check(32'(irq), 32'h0);
    rd(AddrIrqStat, v);
    check(v, 32'h0);
    final_report();
  end
endmodule // dfs_fault_status_tb_top
`default_nettype wire
